// File: hdl/spi_port_consts.vh
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

// ----------------------------------------------------------------------
// Chip select configuration word layout.
// ----------------------------------------------------------------------
`define CFG_CPOL_BIT   0
`define CFG_INVERTED_PHASE_BIT_BIT  1
`define CFG_HOLD_BIT   3
`define CFG_BITS_LSB   4
`define CFG_BITS_MSB   7
`define CFG_DIV_LSB    8
`define CFG_DIV_MSB    15
`define CFG_WIDTH      16
`define CFG_RESET      16'h0000

// ----------------------------------------------------------------------
// Transmit word layout.
// ----------------------------------------------------------------------
`define TX_DATA_MSB    15
`define TX_PCS_LSB     16
`define TX_LAST_BIT    24
`define TX_WIDTH       25

// ----------------------------------------------------------------------
// Sizes, counts and idle levels.
// ----------------------------------------------------------------------
`define FIFO_DEPTH     8
`define FIFO_AW        3
`define BITS_BASE      5'h08
`define BITS_CODE_MAX  4'h8
`define BITS_LONGEST   5'h10
`define PIN_IDLE       4'h2

`endif

// File: hdl/stream_fifo.v
module stream_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset.
    input  wire             core_clk_i,
    input  wire             reset_n_i,
    input  wire             flush_i,
    // Filling side.
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             in_ready_o,
    // Draining side.
    output wire             out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i
);
    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW:0]      wr_q;
    reg  [AW:0]      rd_q;
    wire             empty = (wr_q == rd_q);
    wire             full  = (wr_q[AW] != rd_q[AW]) &&
                             (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire             push  = in_valid_i && !full;
    wire             pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];

    // ------------------------------------------------------------------
    // Storage has no reset; only the pointers carry control state.
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // stream_fifo

// File: hdl/serial_clock_divider.v
module serial_clock_divider (
    // Clock and reset.
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    // Control.
    input  wire       restart_i,
    input  wire [7:0] divider_i,
    // Edge strobe.
    output wire       tick_o
);
    reg  [7:0] count_q;
    // A divider of zero behaves as one, so the engine never stalls.
    wire [7:0] reload = (divider_i == 8'h00) ? 8'h00 : divider_i - 8'h01;

    assign tick_o = (count_q == 8'h00) && !restart_i;

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= 8'h00;
        end else if (restart_i || count_q == 8'h00) begin
            count_q <= reload;
        end else begin
            count_q <= count_q - 8'h01;
        end
    end
endmodule // serial_clock_divider

// File: hdl/serial_peripheral_port.v
`include "spi_port_consts.vh"

module serial_peripheral_port (
    // Clock and reset.
    input  wire        core_clk_i,
    input  wire        reset_n_i,
    // Mode control.
    input  wire        enable_i,
    input  wire        soft_reset_i,
    input  wire        master_select_bit_i,
    input  wire        fixed_select_i,
    input  wire [1:0]  fixed_cs_i,
    // Chip select configuration writes.
    input  wire        cfg_wr_i,
    input  wire [1:0]  cfg_sel_i,
    input  wire [15:0] cfg_data_i,
    // Transmit words from the DMA channel.
    input  wire        tx_valid_i,
    input  wire [24:0] tx_data_i,
    output wire        tx_ready_o,
    output wire        transmit_empty_flag_o,
    output wire        xfer_halfword_o,
    // Received words.
    output wire [15:0] rx_data_o,
    output wire        rx_valid_o,
    // Serial clock pin.
    input  wire        serial_clock_pin_i,
    output wire        serial_clock_pin_o,
    output wire        serial_clock_pin_oe_n_o,
    // Master-out data pin.
    input  wire        mosi_i,
    output wire        mosi_o,
    output wire        mosi_oe_n_o,
    // Master-in data pin.
    input  wire        miso_i,
    output wire        miso_o,
    output wire        miso_oe_n_o,
    // Chip selects.
    input  wire        slave_select_n_i,
    output wire [3:0]  cs_n_o,
    output wire        cs_oe_n_o
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_TAIL  = 2'h2;

    function [4:0] bit_count;
        input [3:0] code;
        begin
            bit_count = (code > `BITS_CODE_MAX) ? `BITS_LONGEST :
                        {1'b0, code} + `BITS_BASE;
        end
    endfunction

    function is_div1;
        input [7:0] div;
        begin
            is_div1 = (div <= 8'h01);
        end
    endfunction

    reg  [1:0]  st_q;
    reg  [1:0]  cur_cs_q;
    reg  [15:0] word_q;
    reg  [3:0]  idx_q;
    reg  [4:0]  bitc_q;
    reg  [5:0]  ecnt_q;
    reg  [15:0] rx_q;
    reg  [15:0] rx_data_q;
    reg         rx_valid_q;
    reg         sck_q;
    reg         mosi_q;
    reg         miso_q;
    reg         last_q;
    reg         extra_q;
    reg         cs_held_q;
    reg         dup_q;
    reg         prev_slow_q;
    reg         glitch_q;
    reg         sck_prev_q;
    reg         sl_busy_q;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    wire [3:0] pin_raw = {miso_i, mosi_i, slave_select_n_i,
                          serial_clock_pin_i};
    wire [3:0] pin_st;
    wire [63:0] cfg_flat;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_port
            localparam [1:0] IDX = g;
            localparam [3:0] IDLE_V = `PIN_IDLE >> g;
            reg [2:0]  sh_q;
            reg        st_q;
            reg [15:0] cfg_q;
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sh_q <= {3{IDLE_V[0]}};
                    st_q <= IDLE_V[0];
                end else begin
                    sh_q <= {sh_q[1:0], pin_raw[g]};
                    if (sh_q[1] == sh_q[2]) begin
                        st_q <= sh_q[2];
                    end
                end
            end
            // Configuration of chip select g.
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cfg_q <= `CFG_RESET;
                end else if (soft_reset_i) begin
                    cfg_q <= `CFG_RESET;
                end else if (cfg_wr_i && cfg_sel_i == IDX) begin
                    cfg_q <= cfg_data_i;
                end
            end
            assign pin_st[g] = st_q;
            assign cfg_flat[16*g +: 16] = cfg_q;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Configuration views.
    // ------------------------------------------------------------------
    wire        fifo_valid;
    wire [24:0] fifo_data;
    wire        fifo_in_ready;
    wire        tick;
    wire [1:0]  head_cs  = fixed_select_i ? fixed_cs_i :
                           fifo_data[`TX_PCS_LSB +: 2];
    wire [15:0] head_cfg = cfg_flat[{head_cs, 4'h0} +: 16];
    wire [15:0] cur_cfg  = cfg_flat[{cur_cs_q, 4'h0} +: 16];
    wire [15:0] cs0_cfg  = cfg_flat[15:0];
    wire [7:0]  head_div = head_cfg[`CFG_DIV_MSB:`CFG_DIV_LSB];
    wire [4:0]  head_bits = bit_count(head_cfg[`CFG_BITS_MSB:`CFG_BITS_LSB]);
    wire [4:0]  cur_bits  = bit_count(cur_cfg[`CFG_BITS_MSB:`CFG_BITS_LSB]);
    wire [4:0]  cs0_bits  = bit_count(cs0_cfg[`CFG_BITS_MSB:`CFG_BITS_LSB]);
    wire [4:0]  head_m1  = head_bits - 5'h01;
    wire [4:0]  cs0_m1   = cs0_bits - 5'h01;
    wire [5:0]  last_edge = {cur_bits, 1'b0} - 6'h01;
    wire        cur_inverted_phase_bit = cur_cfg[`CFG_INVERTED_PHASE_BIT_BIT];
    wire        cpol0    = cs0_cfg[`CFG_CPOL_BIT];
    wire        ncpha0   = cs0_cfg[`CFG_INVERTED_PHASE_BIT_BIT];

    // ------------------------------------------------------------------
    // Master control terms.
    // ------------------------------------------------------------------
    wire master   = master_select_bit_i;
    wire run      = master && enable_i;
    wire load     = run && st_q == ST_IDLE && fifo_valid && !glitch_q;
    // A held select reloaded at divider 1 loses its ready; the word stays.
    wire dup      = load && cs_held_q && head_cs == cur_cs_q && !dup_q &&
                    head_cfg[`CFG_HOLD_BIT] && is_div1(head_div);
    wire m_sample = (ecnt_q[0] == 1'b0) == cur_inverted_phase_bit;
    // A slave listens on the master-out line, a master on master-in.
    wire [15:0] rx_shift = {rx_q[14:0], master ? pin_st[3] : pin_st[2]};
    wire fin      = tick && ((st_q == ST_SHIFT && ecnt_q == last_edge &&
                              !extra_q) ||
                             (st_q == ST_TAIL && ecnt_q[0]));

    // ------------------------------------------------------------------
    // Slave control terms.
    // ------------------------------------------------------------------
    wire sl_sel    = !master && !pin_st[1];
    wire sck_edge  = pin_st[0] != sck_prev_q;
    wire lead      = sck_edge && sck_prev_q == cpol0;
    wire trail     = sck_edge && !lead;
    wire sl_sample = sl_sel && (ncpha0 ? lead : trail);
    wire sl_drive  = sl_sel && (ncpha0 ? trail : lead);
    wire s_load    = sl_sel && !sl_busy_q;
    wire fifo_pop  = (load && !dup) || (s_load && fifo_valid);

    // Fixed mode sizes every DMA word from select zero, whatever is chosen.
    assign xfer_halfword_o = fixed_select_i ?
        (cs0_cfg[`CFG_BITS_MSB:`CFG_BITS_LSB] != 4'h0) :
        (head_cfg[`CFG_BITS_MSB:`CFG_BITS_LSB] != 4'h0);

    stream_fifo #(
        .WIDTH (`TX_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_tx_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .flush_i     (soft_reset_i),
        .in_valid_i  (tx_valid_i && !dup_q),
        .in_data_i   (tx_data_i),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    serial_clock_divider u_div (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .restart_i  (load),
        .divider_i  (cur_cfg[`CFG_DIV_MSB:`CFG_DIV_LSB]),
        .tick_o     (tick)
    );

    // ------------------------------------------------------------------
    // Shift engine for both roles.
    // ------------------------------------------------------------------
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q        <= ST_IDLE;
            cur_cs_q    <= 2'h0;
            word_q      <= 16'h0000;
            idx_q       <= 4'h0;
            bitc_q      <= 5'h00;
            ecnt_q      <= 6'h00;
            rx_q        <= 16'h0000;
            rx_data_q   <= 16'h0000;
            rx_valid_q  <= 1'b0;
            sck_q       <= 1'b0;
            mosi_q      <= 1'b0;
            miso_q      <= 1'b0;
            last_q      <= 1'b0;
            extra_q     <= 1'b0;
            cs_held_q   <= 1'b0;
            dup_q       <= 1'b0;
            prev_slow_q <= 1'b0;
            glitch_q    <= 1'b0;
            sck_prev_q  <= 1'b0;
            sl_busy_q   <= 1'b0;
        end else if (soft_reset_i) begin
            st_q        <= ST_IDLE;
            rx_valid_q  <= 1'b0;
            cs_held_q   <= 1'b0;
            dup_q       <= 1'b0;
            glitch_q    <= 1'b0;
            sl_busy_q   <= 1'b0;
            sck_q       <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            sck_prev_q <= pin_st[0];
            // An early config write leaves a one-cycle clock glitch armed.
            glitch_q <= (cfg_wr_i && !master) || (glitch_q && !master);
            if (master) begin
                case (st_q)
                    ST_IDLE: begin
                        if (!run) begin
                            cs_held_q <= 1'b0;
                        end
                        if (load) begin
                            st_q      <= ST_SHIFT;
                            cur_cs_q  <= head_cs;
                            word_q    <= fifo_data[`TX_DATA_MSB:0];
                            last_q    <= fifo_data[`TX_LAST_BIT];
                            idx_q     <= head_m1[3:0];
                            ecnt_q    <= 6'h00;
                            dup_q     <= dup;
                            cs_held_q <= 1'b0;
                            sck_q     <= head_cfg[`CFG_CPOL_BIT];
                            mosi_q    <= fifo_data[head_m1[3:0]];
                            // Odd length at divider 1 costs one more pulse.
                            extra_q   <= (is_div1(head_div) &&
                                          head_bits[0]) ||
                                         (head_cfg[`CFG_CPOL_BIT] &&
                                          !head_cfg[`CFG_INVERTED_PHASE_BIT_BIT] &&
                                          is_div1(head_div) &&
                                          prev_slow_q);
                        end else begin
                            sck_q <= glitch_q ^
                                     cur_cfg[`CFG_CPOL_BIT];
                        end
                    end
                    ST_SHIFT: begin
                        if (tick) begin
                            sck_q  <= ~sck_q;
                            ecnt_q <= ecnt_q + 6'h01;
                            if (m_sample) begin
                                rx_q  <= rx_shift;
                                idx_q <= idx_q - 4'h1;
                            end else begin
                                mosi_q <= word_q[idx_q];
                            end
                            if (ecnt_q == last_edge && extra_q) begin
                                st_q   <= ST_TAIL;
                                ecnt_q <= 6'h00;
                            end
                        end
                    end
                    ST_TAIL: begin
                        if (tick) begin
                            sck_q  <= ~sck_q;
                            ecnt_q <= ecnt_q + 6'h01;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
                if (fin) begin
                    st_q        <= ST_IDLE;
                    rx_data_q   <= (st_q == ST_SHIFT && m_sample) ?
                                   rx_shift : rx_q;
                    rx_valid_q  <= 1'b1;
                    prev_slow_q <= !is_div1(cur_cfg[`CFG_DIV_MSB:
                                                    `CFG_DIV_LSB]);
                    // Last-word flag drops the held select at the end of that word.
                    cs_held_q   <= cur_cfg[`CFG_HOLD_BIT] && !last_q;
                end
            end else begin
                // Slave keeps running whatever the enable says.
                st_q      <= ST_IDLE;
                cs_held_q <= 1'b0;
                if (!sl_sel) begin
                    sl_busy_q <= 1'b0;
                end else if (s_load) begin
                    sl_busy_q <= 1'b1;
                    rx_q      <= 16'h0000;
                    word_q    <= fifo_valid ? fifo_data[`TX_DATA_MSB:0] :
                                 16'h0000;
                    idx_q     <= cs0_m1[3:0];
                    bitc_q    <= 5'h00;
                    miso_q    <= fifo_valid && fifo_data[cs0_m1[3:0]];
                end else if (sl_sample) begin
                    rx_q   <= rx_shift;
                    idx_q  <= idx_q - 4'h1;
                    bitc_q <= bitc_q + 5'h01;
                    if (bitc_q == cs0_m1) begin
                        rx_data_q  <= rx_shift;
                        rx_valid_q <= 1'b1;
                        sl_busy_q  <= 1'b0;
                    end
                end else if (sl_drive) begin
                    miso_q <= word_q[idx_q];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    wire [3:0] cs_onehot = 4'h1 << cur_cs_q;
    wire       cs_active = master && (st_q != ST_IDLE || cs_held_q);

    // The stuck ready lasts until the held word goes out a second time.
    assign tx_ready_o            = fifo_in_ready && !dup_q;
    assign transmit_empty_flag_o = !fifo_valid && st_q == ST_IDLE &&
                                   !dup_q;
    assign rx_data_o             = rx_data_q;
    assign rx_valid_o            = rx_valid_q;
    assign serial_clock_pin_o    = sck_q;
    assign serial_clock_pin_oe_n_o = !master;
    assign mosi_o                = mosi_q;
    assign mosi_oe_n_o           = !master;
    assign miso_o                = miso_q;
    assign miso_oe_n_o           = !sl_sel;
    assign cs_n_o                = ~(cs_onehot & {4{cs_active}});
    assign cs_oe_n_o             = !master;
endmodule // serial_peripheral_port

// File: verif/serial_peripheral_port_asserts.sv
module serial_peripheral_port_asserts (
    input wire        core_clk_i, reset_n_i, soft_reset_i, enable_i,
    input wire        master_select_bit_i, fixed_select_i, cfg_wr_i,
    input wire        tx_valid_i, tx_ready_o, transmit_empty_flag_o,
    input wire        xfer_halfword_o, rx_valid_o, serial_clock_pin_oe_n_o,
    input wire        mosi_oe_n_o, miso_oe_n_o, slave_select_n_i, cs_oe_n_o,
    input wire [1:0]  cfg_sel_i,
    input wire [15:0] cfg_data_i,
    input wire [3:0]  cs_n_o
);
    reg [3:0] code0_q;
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            code0_q <= 4'h0;
        else if (soft_reset_i)
            code0_q <= 4'h0;
        else if (cfg_wr_i && cfg_sel_i == 2'h0)
            code0_q <= cfg_data_i[7:4];
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    pins_owned_a: assert property (
        cs_oe_n_o == !master_select_bit_i && mosi_oe_n_o == !master_select_bit_i
        && serial_clock_pin_oe_n_o == !master_select_bit_i)
        else $error("pin enables wrong");
    empty_ready_a: assert property (
        transmit_empty_flag_o |-> tx_ready_o)
        else $error("ready low while empty");
    halfword_size_a: assert property (
        fixed_select_i |-> xfer_halfword_o == (code0_q != 4'h0))
        else $error("size not from select zero");
    rx_pulse_a: assert property (
        rx_valid_o |=> !rx_valid_o)
        else $error("long receive strobe");
    one_select_a: assert property (
        $onehot0(~cs_n_o))
        else $error("more than one chip select low");
    slave_release_a: assert property (
        (!master_select_bit_i && slave_select_n_i) [*5] |-> miso_oe_n_o)
        else $error("deselected slave drives");
    load_select_a: assert property (
        master_select_bit_i && enable_i && transmit_empty_flag_o && tx_valid_i
        && tx_ready_o && !soft_reset_i |-> ##[1:3] cs_n_o != 4'hf)
        else $error("no select after load");
    stay_empty_a: assert property (
        master_select_bit_i && transmit_empty_flag_o && !tx_valid_i
        |=> transmit_empty_flag_o)
        else $error("empty flag fell without a word");
    cover property (rx_valid_o && master_select_bit_i);
    cover property (rx_valid_o && !master_select_bit_i);
    cover property (!tx_ready_o && !transmit_empty_flag_o);
endmodule // serial_peripheral_port_asserts

bind serial_peripheral_port serial_peripheral_port_asserts u_checker (.*);

// File: verif/spi_slave_model.sv
module spi_slave_model #(parameter int BITS = 8) (
    input  wire         sck_i, mosi_i, select_n_i,
    input  wire [15:0]  reply_i,
    output logic        miso_o = 1'b0,
    output logic [15:0] got_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    int idx = 0;
    always @(negedge select_n_i) begin
        idx = BITS - 1;
        miso_o = reply_i[idx];
    end
    // A released line shows the inverse so a stale bit is never read.
    always @(posedge select_n_i) miso_o = ~miso_o;
    always @(posedge sck_i) if (!select_n_i) got_o = {got_o[14:0], mosi_i};
    always @(negedge sck_i) begin
        if (!select_n_i && idx > 0) begin
            idx = idx - 1;
            miso_o = reply_i[idx];
        end
    end
endmodule // spi_slave_model

// File: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, enable = 1'b0, soft_reset = 1'b0;
    logic master = 1'b0, fixed = 1'b0, cfg_wr = 1'b0, tx_valid = 1'b0;
    logic [1:0] fixed_cs = 2'h0, cfg_sel = 2'h0;
    logic [15:0] cfg_data = 16'h0000, reply = 16'h003c;
    logic [24:0] tx_data = 25'h0000000;
    logic ext_sck = 1'b0, ext_mosi = 1'b0, ext_sel_n = 1'b1, sck_prev = 1'b0;
    logic ready_dropped = 1'b0;
    int err_count = 0, check_count = 0, toggles = 0, rx_count = 0, cycles = 0;
    wire tx_ready, tx_empty, halfword, rx_valid, sck, sck_oe_n, model_miso;
    wire mosi, mosi_oe_n, miso, miso_oe_n, cs_oe_n;
    wire [15:0] rx_data, got;
    wire [3:0] cs_n;
    wire sck_w = sck_oe_n ? ext_sck : sck;
    wire mosi_w = mosi_oe_n ? ext_mosi : mosi;
    wire miso_w = miso_oe_n ? model_miso : miso;
    serial_peripheral_port dut (.core_clk_i(clk), .reset_n_i(reset_n),
        .enable_i(enable), .soft_reset_i(soft_reset),
        .master_select_bit_i(master), .fixed_select_i(fixed),
        .fixed_cs_i(fixed_cs), .cfg_wr_i(cfg_wr), .cfg_sel_i(cfg_sel),
        .cfg_data_i(cfg_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .transmit_empty_flag_o(tx_empty),
        .xfer_halfword_o(halfword), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .serial_clock_pin_i(sck_w),
        .serial_clock_pin_o(sck), .serial_clock_pin_oe_n_o(sck_oe_n),
        .mosi_i(mosi_w), .mosi_o(mosi), .mosi_oe_n_o(mosi_oe_n),
        .miso_i(miso_w), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
        .slave_select_n_i(ext_sel_n), .cs_n_o(cs_n), .cs_oe_n_o(cs_oe_n));
    spi_slave_model #(.BITS(8)) slave (.sck_i(sck_w), .mosi_i(mosi_w),
        .select_n_i(cs_n[0]), .miso_o(model_miso), .reply_i(reply),
        .got_o(got));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        sck_prev <= sck_w;
        if (sck_w !== sck_prev) toggles <= toggles + 1;
        if (rx_valid === 1'b1) rx_count <= rx_count + 1;
        if (tx_ready === 1'b0 && tx_empty === 1'b0 && !tx_valid)
            ready_dropped <= 1'b1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp) begin
            err_count++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task automatic write_cfg(input logic [1:0] sel, input logic [15:0] val);
        @(negedge clk);
        {cfg_wr, cfg_sel, cfg_data} = {1'b1, sel, val};
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task automatic push(input logic [24:0] word);
        int n = 0;
        @(negedge clk);
        {tx_valid, tx_data} = {1'b1, word};
        while (tx_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task automatic wait_idle();
        int n = 0;
        @(negedge clk);
        while (tx_empty !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
        check(16'h0001, {15'h0, tx_empty});
    endtask
    task automatic pulse_soft_reset();
        @(negedge clk) soft_reset = 1'b1;
        @(negedge clk) soft_reset = 1'b0;
    endtask
    task automatic t_exchange();
        {master, enable} = 2'b11;
        write_cfg(2'h0, 16'h0802);
        {toggles, rx_count} = 0;
        push({1'b1, 6'h00, 2'h0, 16'h00a5});
        wait_idle();
        check(16'h0010, 16'(toggles));
        check(16'h003c, rx_data);
        check(16'h00a5, got & 16'h00ff);
        check(16'h000f, {12'h000, cs_n});
    endtask
    task automatic t_div1();
        for (int c = 1; c <= 4; c++) begin
            write_cfg(2'h0, {8'h01, 4'(c), 4'h2});
            toggles = 0;
            push({1'b1, 8'h00, 16'h0155});
            wait_idle();
            check(16'(2 * (8 + c) + 2 * (c % 2)), 16'(toggles));
        end
    endtask
    task automatic t_mixed();
        for (int k = 0; k < 2; k++) begin
            write_cfg(2'h1, k ? 16'h0101 : 16'h0201);
            write_cfg(2'h0, 16'h0101);
            push({1'b1, 6'h00, 2'h1, 16'h0055});
            wait_idle();
            toggles = 0;
            push({1'b1, 6'h00, 2'h0, 16'h0033});
            wait_idle();
            check(k ? 16'h0010 : 16'h0012, 16'(toggles));
        end
    endtask
    task automatic t_fixed();
        {fixed, fixed_cs} = {1'b1, 2'h1};
        write_cfg(2'h1, 16'h080a);
        write_cfg(2'h0, 16'h0822);
        check(16'h0001, 16'(halfword));
        write_cfg(2'h0, 16'h0802);
        check(16'h0000, 16'(halfword));
        push({1'b0, 8'h00, 16'h005a});
        wait_idle();
        check(16'h000d, 16'(cs_n));
        push({1'b1, 8'h00, 16'h00a6});
        wait_idle();
        check(16'h000f, 16'(cs_n));
        fixed = 1'b0;
    endtask
    task automatic t_fifo();
        enable = 1'b0;
        write_cfg(2'h0, 16'h0102);
        rx_count = 0;
        for (int w = 0; w < 8; w++) push({1'b1, 8'h00, 16'(w)});
        check(16'h0000, {15'h0, tx_ready});
        enable = 1'b1;
        wait_idle();
        check(16'h0008, 16'(rx_count));
    endtask
    task automatic t_duplicate();
        write_cfg(2'h0, 16'h010a); // Hold with divider 1 on purpose.
        {rx_count, ready_dropped} = 0;
        push({1'b0, 8'h00, 16'h0011});
        wait_idle();
        push({1'b0, 8'h00, 16'h0022});
        wait_idle();
        check(16'h0001, {15'h0, ready_dropped});
        check(16'h0003, 16'(rx_count));
    endtask
    task automatic t_glitch();
        for (int k = 0; k < 2; k++) begin
            pulse_soft_reset();
            master = k[0];
            write_cfg(2'h0, 16'h0802);
            toggles = 0;
            master = 1'b1;
            repeat (8) @(negedge clk);
            check(k ? 16'h0000 : 16'h0002, 16'(toggles));
        end
    endtask
    task automatic t_slave();
        logic [7:0] word;
        word = 8'hc3;
        pulse_soft_reset();
        {master, enable, rx_count} = 0;
        write_cfg(2'h0, 16'h0802);
        @(negedge clk) ext_sel_n = 1'b0;
        for (int b = 7; b >= 0; b--) begin
            repeat (8) @(negedge clk) ext_mosi = word[b];
            @(negedge clk) ext_sck = 1'b1;
            repeat (8) @(negedge clk);
            ext_sck = 1'b0;
        end
        repeat (8) @(negedge clk);
        ext_sel_n = 1'b1;
        check(16'h00c3, rx_data);
        check(16'h0001, 16'(rx_count));
        pulse_soft_reset();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        check(16'h001f, {11'h0, tx_ready, tx_empty, 3'h7});
        check(16'h000f, {12'h000, cs_n});
        t_exchange();
        t_div1();
        t_mixed();
        t_fixed();
        t_fifo();
        t_duplicate();
        t_glitch();
        t_slave();
        tally_and_finish();
    end
endmodule // tb_top
